// ### rtl/optical_module_ctrl_status.sv
`timescale 1ns/1ps
module optical_module_ctrl_status
    import omcs_pkg::*;
#(
    parameter int unsigned SERIAL_READY_CYC = SERIAL_CYC,
    parameter int unsigned DATA_READY_CYC   = DATA_CYC,
    parameter int unsigned WR_SHORT_BUSY    = WR_SHORT_CYC,
    parameter int unsigned WR_LONG_BUSY     = WR_LONG_CYC
) (
    // reference clock and reset
    input  wire logic REF_CLK_I,
    input  wire logic SRST_I,
    // host control pins
    input  wire logic LASER_OFF_I,
    output logic      LASER_FAULT_O,
    output logic      RX_SIGNAL_LOST_O,
    // management bus, open drain
    input  wire logic SCL_I,
    output logic      SCL_O,
    output logic      SCL_OE_O,
    input  wire logic SDA_I,
    output logic      SDA_O,
    output logic      SDA_OE_O,
    // optics side, link clock domain
    input  wire logic LINK_CLK_I,
    input  wire logic LASER_FAULT_DET_I,
    input  wire logic OPTICAL_OK_I,
    output logic      LASER_EN_O
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        bus_state_t  st;
        logic [7:0]  shreg;
        logic [3:0]  cnt;
        logic        rd;
        logic        diag;
        logic [7:0]  ptr;
        logic [7:0]  txbyte;
        logic        sda_oe;
        logic [3:0]  nbytes;
        logic        pend_soft;
        logic        pend_valid;
        logic        soft_off;
        logic        fault;
        logic [9:0]  hold_cnt;
        logic [26:0] por_cnt;
        logic        bus_ready;
        logic        data_ready;
        logic [22:0] busy_cnt;
        logic        busy;
        logic [5:0]  str_cnt;
        logic        scl_q;
        logic        sda_q;
        logic        off_q;
        logic        laser_on;
        logic        fault_pin;
        logic        los_pin;
    } top_state_t;

    top_state_t   s_q;
    top_state_t   s_d;
    logic [2:0]   pin_sync;
    logic         scl_s;
    logic         sda_s;
    logic         off_s;
    link_status_t link_st;
    link_status_t link_sync;

    // ----------------------------------------
    // crossings
    // ----------------------------------------
    omcs_sync2 #(.W(3)) u_pin_sync (
        .clk_i (REF_CLK_I),
        .d_i   ({SCL_I, SDA_I, LASER_OFF_I}),
        .q_o   (pin_sync)
    );

    assign scl_s = pin_sync[2];
    assign sda_s = pin_sync[1];
    assign off_s = pin_sync[0];

    omcs_sync2 #(.W(2)) u_link_sync (
        .clk_i (REF_CLK_I),
        .d_i   (link_st),
        .q_o   (link_sync)
    );

    omcs_link_side u_link (
        .link_clk_i        (LINK_CLK_I),
        .srst_i            (SRST_I),
        .laser_on_i        (s_q.laser_on),
        .laser_fault_det_i (LASER_FAULT_DET_I),
        .optical_ok_i      (OPTICAL_OK_I),
        .laser_en_o        (LASER_EN_O),
        .status_o          (link_st)
    );

    // ----------------------------------------
    // register read decode
    // ----------------------------------------
    function automatic logic [7:0] read_byte(input top_state_t s, input logic [7:0] addr);
        logic [7:0] v;
        v = 8'h00;
        if (s.diag && addr == REG_CTRL_STAT) begin
            v[BIT_OFF_STATE] = s.off_q;
            v[BIT_SOFT_OFF]  = s.soft_off;
            v[BIT_FAULT]     = s.fault;
            // R9 status bit tracks the lost pin
            v[BIT_LOS]       = s.los_pin;
            v[BIT_DATA_RDY]  = s.data_ready;
        end
        return v;
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic [7:0] rb;
        s_d      = s_q;
        scl_rise = scl_s & ~s_q.scl_q;
        scl_fall = ~scl_s & s_q.scl_q;
        start    = scl_s & s_q.scl_q & s_q.sda_q & ~sda_s;
        stop     = scl_s & s_q.scl_q & ~s_q.sda_q & sda_s;
        rb       = read_byte(s_q, s_q.ptr);

        s_d.scl_q = scl_s;
        s_d.sda_q = sda_s;
        s_d.off_q = off_s;

        // R5 time the laser-off high phase
        if (off_s) begin
            if (s_q.hold_cnt != 10'(T_RESET_CYC)) begin
                s_d.hold_cnt = s_q.hold_cnt + 10'd1;
            end
        end else begin
            s_d.hold_cnt = '0;
        end
        // R3 long enough pulse clears the latched fault
        if (s_q.off_q && !off_s && s_q.hold_cnt == 10'(T_RESET_CYC)) begin
            s_d.fault = 1'b0;
        end
        // R8 fault set wins over a clearing pulse
        if (link_sync.fault) begin
            s_d.fault = 1'b1;
        end

        // R4 fault pin follows latch
        s_d.fault_pin = s_q.fault;
        // R6 signal-lost pin follows detector
        s_d.los_pin   = ~link_sync.signal_ok;
        // R2 light back once laser-off drops
        s_d.laser_on  = ~off_s & ~s_q.soft_off & ~s_q.fault;

        // R10 power-on counter for bus and data ready
        if (!s_q.data_ready) begin
            s_d.por_cnt = s_q.por_cnt + 27'd1;
            // R11 bus comes alive
            if (s_q.por_cnt == 27'(SERIAL_READY_CYC)) begin
                s_d.bus_ready = 1'b1;
            end
            if (s_q.por_cnt == 27'(DATA_READY_CYC)) begin
                s_d.data_ready = 1'b1;
                s_d.bus_ready  = 1'b1;
            end
        end

        // R13 internal write timer
        if (s_q.busy) begin
            if (s_q.busy_cnt == '0) begin
                s_d.busy = 1'b0;
            end else begin
                s_d.busy_cnt = s_q.busy_cnt - 23'd1;
            end
        end

        // R16 stretch counter
        if (s_q.str_cnt != '0) begin
            s_d.str_cnt = s_q.str_cnt - 6'd1;
        end

        // ----------------------------------------
        // management bus slave
        // ----------------------------------------
        if (start && s_q.bus_ready) begin
            s_d.st     = ST_ADDR;
            s_d.cnt    = '0;
            s_d.sda_oe = 1'b0;
            s_d.nbytes = '0;
        end else if (stop) begin
            s_d.st     = ST_IDLE;
            s_d.sda_oe = 1'b0;
            // R7 soft bit takes effect at stop
            if (s_q.pend_valid) begin
                s_d.soft_off   = s_q.pend_soft;
                s_d.pend_valid = 1'b0;
            end
            // R13 busy time chosen by byte count
            if (s_q.nbytes != '0) begin
                s_d.busy     = 1'b1;
                s_d.busy_cnt = (s_q.nbytes <= WR_SHORT_MAX) ? 23'(WR_SHORT_BUSY) : 23'(WR_LONG_BUSY);
                s_d.nbytes   = '0;
            end
        end else begin
            unique case (s_q.st)
                ST_IDLE: begin
                end
                ST_ADDR, ST_WR_PTR, ST_WR_DATA: begin
                    if (scl_rise) begin
                        s_d.shreg = {s_q.shreg[6:0], sda_s};
                        s_d.cnt   = s_q.cnt + 4'd1;
                    end else if (scl_fall && s_q.cnt == 4'd8) begin
                        s_d.cnt = '0;
                        if (s_q.st == ST_ADDR) begin
                            // R17 stay silent while writing
                            if ((s_q.shreg[7:1] == DEV_ADDR_ID || s_q.shreg[7:1] == DEV_ADDR_DIAG) && !s_q.busy) begin
                                s_d.sda_oe = 1'b1;
                                s_d.diag   = (s_q.shreg[7:1] == DEV_ADDR_DIAG);
                                s_d.rd     = s_q.shreg[0];
                                s_d.st     = ST_ADDR_ACK;
                            end else begin
                                s_d.st = ST_IDLE;
                            end
                        end else if (s_q.st == ST_WR_PTR) begin
                            s_d.ptr    = s_q.shreg;
                            s_d.sda_oe = 1'b1;
                            s_d.st     = ST_WR_ACK;
                        end else if (s_q.nbytes != WR_MAX_BYTES) begin
                            if (s_q.diag && s_q.ptr == REG_CTRL_STAT) begin
                                s_d.pend_soft  = s_q.shreg[BIT_SOFT_OFF];
                                s_d.pend_valid = 1'b1;
                            end
                            s_d.nbytes  = s_q.nbytes + 4'd1;
                            s_d.ptr     = s_q.ptr + 8'd1;
                            s_d.sda_oe  = 1'b1;
                            // R16 hold clock low while the byte lands
                            s_d.str_cnt = 6'(STRETCH_CYC);
                            s_d.st      = ST_WR_ACK;
                        end else begin
                            // ninth byte is refused
                            s_d.st = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RD_ACK: begin
                    if (s_q.st == ST_RD_ACK && scl_rise && sda_s) begin
                        s_d.st = ST_IDLE;
                    end else if (scl_fall) begin
                        if (s_q.rd) begin
                            s_d.txbyte = rb;
                            s_d.sda_oe = ~rb[7];
                            s_d.ptr    = s_q.ptr + 8'd1;
                            s_d.cnt    = 4'd1;
                            s_d.st     = ST_RD_DATA;
                        end else begin
                            s_d.sda_oe = 1'b0;
                            s_d.cnt    = '0;
                            s_d.st     = ST_WR_PTR;
                        end
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        s_d.sda_oe = 1'b0;
                        s_d.cnt    = '0;
                        s_d.st     = ST_WR_DATA;
                    end
                end
                ST_RD_DATA: begin
                    if (scl_fall) begin
                        if (s_q.cnt == 4'd8) begin
                            s_d.sda_oe = 1'b0;
                            s_d.st     = ST_RD_ACK;
                        end else begin
                            s_d.txbyte = {s_q.txbyte[6:0], 1'b0};
                            s_d.sda_oe = ~s_q.txbyte[6];
                            s_d.cnt    = s_q.cnt + 4'd1;
                        end
                    end
                end
                default: begin
                    s_d.st = ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            s_q          <= '0;
            s_q.st       <= ST_IDLE;
            s_q.soft_off <= SOFT_OFF_RST;
            s_q.scl_q    <= 1'b1;
            s_q.sda_q    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign LASER_FAULT_O    = s_q.fault_pin;
    assign RX_SIGNAL_LOST_O = s_q.los_pin;
    assign SCL_O            = 1'b0;
    assign SCL_OE_O         = (s_q.str_cnt != '0);
    assign SDA_O            = 1'b0;
    assign SDA_OE_O         = s_q.sda_oe;

endmodule

// ### rtl/omcs_pkg.sv
// How it works
// R1 - laser-off rise kills light within 10 us
// R2 - laser-off fall restores light within 1 ms
// R3 - init clears fault within 300 ms
// R4 - fault pin active within 1 ms of fault
// R5 - host holds laser-off 10 us to clear
// R6 - signal-lost pin follows input within 100 us
// R7 - soft laser-off bit acts within 100 ms
// R8 - fault status bit set within 100 ms
// R9 - signal-lost status bit follows within 100 ms
// R10 - data-ready bit set within 1000 ms
// R11 - bus answers both addresses by 300 ms
// R12 - host leaves 20 us stop-to-start idle
// R13 - write completes within 40/80 ms
// R14 - host writes one to eight bytes
// R15 - host bus clock at most 400 kHz
// R16 - module may stretch clock; host waits
// R17 - no acknowledge during internal write
package omcs_pkg;

    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned T_RESET_US     = 10;
    localparam int unsigned T_RESET_CYC    = T_RESET_US * CLK_MHZ;
    localparam int unsigned T_SERIAL_MS    = 300;
    localparam int unsigned T_DATA_MS      = 1000;
    localparam int unsigned T_WR_SHORT_MS  = 40;
    localparam int unsigned T_WR_LONG_MS   = 80;
    localparam int unsigned T_STRETCH_NS   = 500;
    localparam int unsigned CLK_PERIOD_NS  = 1000 / CLK_MHZ;
    localparam int unsigned STRETCH_CYC    = T_STRETCH_NS / CLK_PERIOD_NS;
    localparam int unsigned SERIAL_CYC     = T_SERIAL_MS * 1000 * CLK_MHZ;
    localparam int unsigned DATA_CYC       = T_DATA_MS * 1000 * CLK_MHZ;
    localparam int unsigned WR_SHORT_CYC   = T_WR_SHORT_MS * 1000 * CLK_MHZ;
    localparam int unsigned WR_LONG_CYC    = T_WR_LONG_MS * 1000 * CLK_MHZ;

    // ----------------------------------------
    // bus addresses and register map
    // ----------------------------------------
    localparam logic [6:0] DEV_ADDR_ID    = 7'h50;
    localparam logic [6:0] DEV_ADDR_DIAG  = 7'h51;
    localparam logic [7:0] REG_CTRL_STAT  = 8'h6e;
    localparam int unsigned BIT_OFF_STATE = 7;
    localparam int unsigned BIT_SOFT_OFF  = 6;
    localparam int unsigned BIT_FAULT     = 2;
    localparam int unsigned BIT_LOS       = 1;
    localparam int unsigned BIT_DATA_RDY  = 0;
    localparam logic       SOFT_OFF_RST   = 1'b0;
    localparam logic [3:0] WR_MAX_BYTES   = 4'h8;
    localparam logic [3:0] WR_SHORT_MAX   = 4'h4;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0000,
        ST_ADDR     = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_WR_PTR   = 4'b0011,
        ST_WR_DATA  = 4'b0100,
        ST_WR_ACK   = 4'b0101,
        ST_RD_DATA  = 4'b0110,
        ST_RD_ACK   = 4'b0111
    } bus_state_t;

    typedef struct packed {
        logic fault;
        logic signal_ok;
    } link_status_t;

endpackage

// ### rtl/omcs_sync2.sv
`timescale 1ns/1ps
module omcs_sync2 #(
    parameter int unsigned W = 1
) (
    // clock
    input  wire logic         clk_i,
    // data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage is read only by the second
    always_ff @(posedge clk_i) begin
        meta_q <= d_i;
        sync_q <= meta_q;
    end

    assign q_o = sync_q;

endmodule

// ### rtl/omcs_link_side.sv
`timescale 1ns/1ps
module omcs_link_side
    import omcs_pkg::*;
(
    // link clock and reset from the reference domain
    input  wire logic   link_clk_i,
    input  wire logic   srst_i,
    // control from the reference domain
    input  wire logic   laser_on_i,
    // optics pins
    input  wire logic   laser_fault_det_i,
    input  wire logic   optical_ok_i,
    output logic        laser_en_o,
    output link_status_t status_o
);

    typedef struct packed {
        logic         laser_en;
        link_status_t status;
    } link_state_t;

    logic [3:0]  s_sync;
    logic        rst_s;
    link_state_t l_q;
    link_state_t l_d;

    omcs_sync2 #(.W(4)) u_sync (
        .clk_i (link_clk_i),
        .d_i   ({srst_i, laser_on_i, laser_fault_det_i, optical_ok_i}),
        .q_o   (s_sync)
    );

    assign rst_s = s_sync[3];

    // R1 laser follows control; a few link cycles, far under limit
    always_comb begin
        l_d                  = l_q;
        l_d.laser_en         = s_sync[2];
        l_d.status.fault     = s_sync[1];
        l_d.status.signal_ok = s_sync[0];
    end

    always_ff @(posedge link_clk_i) begin
        if (rst_s) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    assign laser_en_o = l_q.laser_en;
    assign status_o   = l_q.status;

endmodule

// ### tb/optical_module_ctrl_status_props.sv
`timescale 1ns/1ps
module omcs_props
    import omcs_pkg::*;
#(
    parameter int unsigned SERIAL_READY_CYC = SERIAL_CYC,
    parameter int unsigned DATA_READY_CYC   = DATA_CYC,
    parameter int unsigned WR_SHORT_BUSY    = WR_SHORT_CYC,
    parameter int unsigned WR_LONG_BUSY     = WR_LONG_CYC
) (
    // clocks and reset
    input wire logic REF_CLK_I,
    input wire logic SRST_I,
    input wire logic LINK_CLK_I,
    // host pins
    input wire logic LASER_OFF_I,
    input wire logic LASER_FAULT_O,
    input wire logic RX_SIGNAL_LOST_O,
    // bus
    input wire logic SCL_I,
    input wire logic SCL_O,
    input wire logic SCL_OE_O,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    // optics
    input wire logic LASER_FAULT_DET_I,
    input wire logic OPTICAL_OK_I,
    input wire logic LASER_EN_O
);
    logic [31:0] up_q;
    logic [15:0] off_q;

    // cycles since reset and length of the current laser-off pulse
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) up_q <= '0;
        else if (up_q < SERIAL_READY_CYC) up_q <= up_q + 32'h1;
        if (SRST_I || !LASER_OFF_I) off_q <= '0;
        else if (off_q != 16'hffff) off_q <= off_q + 16'h1;
    end

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SRST_I);

    // margin over the 1000-cycle hold so a pulse at the edge does not count
    sequence off_released;
        $fell(LASER_OFF_I) && off_q >= 16'h03f2 && !LASER_FAULT_DET_I;
    endsequence
    sequence fault_gone;
        ##[1:1000] !LASER_FAULT_O;
    endsequence

    chk_off_kills_laser:
        assert property ($rose(LASER_OFF_I) |-> ##[1:1000] (!LASER_EN_O || !LASER_OFF_I)) else $error("laser on");
    chk_fault_pin_set:
        assert property ($rose(LASER_FAULT_DET_I) |-> ##[1:1000] (LASER_FAULT_O || !LASER_FAULT_DET_I))
        else $error("fault pin late");
    chk_los_pin_set:
        assert property ($fell(OPTICAL_OK_I) |-> ##[1:1000] (RX_SIGNAL_LOST_O || OPTICAL_OK_I)) else $error("los late");
    chk_los_pin_clear:
        assert property ($rose(OPTICAL_OK_I) |-> ##[1:1000] (!RX_SIGNAL_LOST_O || !OPTICAL_OK_I)) else $error("los stuck");
    chk_fault_reset:
        assert property (off_released |-> fault_gone) else $error("fault not cleared");
    chk_stretch_bound:
        assert property (SCL_OE_O |-> ##[1:60] !SCL_OE_O) else $error("clock held too long");
    chk_bus_ready:
        assert property (SDA_OE_O |-> up_q >= SERIAL_READY_CYC) else $error("answered before ready");
    chk_sda_steady:
        assert property ($changed(SDA_OE_O) |-> !SCL_I) else $error("data moved while clock high");
endmodule

bind optical_module_ctrl_status omcs_props #(
    .SERIAL_READY_CYC(SERIAL_READY_CYC), .DATA_READY_CYC(DATA_READY_CYC),
    .WR_SHORT_BUSY(WR_SHORT_BUSY), .WR_LONG_BUSY(WR_LONG_BUSY)
) props (
    .REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .LINK_CLK_I(LINK_CLK_I), .LASER_OFF_I(LASER_OFF_I),
    .LASER_FAULT_O(LASER_FAULT_O), .RX_SIGNAL_LOST_O(RX_SIGNAL_LOST_O), .SCL_I(SCL_I), .SCL_O(SCL_O),
    .SCL_OE_O(SCL_OE_O), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
    .LASER_FAULT_DET_I(LASER_FAULT_DET_I), .OPTICAL_OK_I(OPTICAL_OK_I), .LASER_EN_O(LASER_EN_O)
);

// ### tb/omcs_host_bfm.sv
`timescale 1ns/1ps
module omcs_host_bfm (
    // clock
    input  wire logic clk_i,
    // resolved wire levels
    input  wire logic scl_i,
    input  wire logic sda_i,
    // open drain: 1 releases the line
    output logic      scl_rel_o,
    output logic      sda_rel_o
);
    // half of a 400 kHz bit at 100 MHz
    localparam int HALF = 125;
    // stop-to-start idle of 20 us plus margin
    localparam int IDLE = 2100;

    initial begin
        scl_rel_o = 1'b1;
        sda_rel_o = 1'b1;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic clk_bit(input logic b, output logic s);
        int w;
        sda_rel_o <= b;
        ticks(HALF);
        scl_rel_o <= 1'b1;
        w = 0;
        do begin ticks(1); w++; end while (scl_i !== 1'b1 && w < 1000);
        ticks(HALF / 2);
        s = sda_i;
        ticks(HALF / 2);
        scl_rel_o <= 1'b0;
        ticks(4);
    endtask

    task automatic bus_start();
        sda_rel_o <= 1'b1;
        ticks(HALF);
        scl_rel_o <= 1'b1;
        ticks(HALF);
        sda_rel_o <= 1'b0;
        ticks(HALF);
        scl_rel_o <= 1'b0;
        ticks(4);
    endtask

    task automatic bus_stop();
        sda_rel_o <= 1'b0;
        ticks(HALF);
        scl_rel_o <= 1'b1;
        ticks(HALF);
        sda_rel_o <= 1'b1;
        ticks(IDLE);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic get_byte(output logic [7:0] d, input logic ack_it);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(~ack_it, s);
    endtask
endmodule

// ### tb/tb_optical_module_ctrl_status.sv
`timescale 1ns/1ps
module tb_optical_module_ctrl_status;
    import omcs_pkg::*;

    logic ref_clk, link_clk, srst, laser_off, fault_det, opt_ok;
    logic fault_pin, los_pin, scl_oe, sda_oe, laser_en, scl_rel, sda_rel;
    logic scl_w, sda_w, scl_o, sda_o;
    int   errors, samples_checked;

    // pull-ups: a line is low if anyone pulls it
    assign scl_w = scl_rel & (~scl_oe | scl_o);
    assign sda_w = sda_rel & (~sda_oe | sda_o);

    optical_module_ctrl_status #(
        .SERIAL_READY_CYC(3000), .DATA_READY_CYC(40000), .WR_SHORT_BUSY(3000), .WR_LONG_BUSY(6000)
    ) DUT (
        .REF_CLK_I(ref_clk), .SRST_I(srst), .LASER_OFF_I(laser_off), .LASER_FAULT_O(fault_pin),
        .RX_SIGNAL_LOST_O(los_pin), .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda_w),
        .SDA_O(sda_o), .SDA_OE_O(sda_oe), .LINK_CLK_I(link_clk), .LASER_FAULT_DET_I(fault_det),
        .OPTICAL_OK_I(opt_ok), .LASER_EN_O(laser_en)
    );

    omcs_host_bfm host (.clk_i(ref_clk), .scl_i(scl_w), .sda_i(sda_w), .scl_rel_o(scl_rel), .sda_rel_o(sda_rel));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        // fractional offset keeps link edges off reference edges
        #7.3;
        forever #24 link_clk = ~link_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic pin(input logic seen, input logic exp, input string what);
        check({7'h00, seen}, {7'h00, exp}, what);
    endtask

    task automatic probe(input logic [6:0] a, input logic want);
        logic ack;
        host.bus_start();
        host.send_byte({a, 1'b0}, ack);
        host.bus_stop();
        pin(ack, want, "address answer");
    endtask

    task automatic read_status(input logic [7:0] exp);
        logic       ack;
        logic [7:0] d;
        host.bus_start();
        host.send_byte({DEV_ADDR_DIAG, 1'b0}, ack);
        host.send_byte(REG_CTRL_STAT, ack);
        host.bus_start();
        host.send_byte({DEV_ADDR_DIAG, 1'b1}, ack);
        host.get_byte(d, 1'b0);
        host.bus_stop();
        check(d, exp, "status byte");
    endtask

    // first byte lands at the status offset, the rest are zeros past it
    task automatic write_status(input logic [7:0] first, input int n);
        logic ack;
        host.bus_start();
        host.send_byte({DEV_ADDR_DIAG, 1'b0}, ack);
        host.send_byte(REG_CTRL_STAT, ack);
        // host keeps to one to eight data bytes
        for (int i = 0; i < n; i++) host.send_byte(i == 0 ? first : 8'h00, ack);
        host.bus_stop();
    endtask

    initial begin
        repeat (99000) @(posedge ref_clk);
        errors++;
        close_out();
    end

    initial begin
        errors = 0;
        samples_checked = 0;
        srst = 1'b1;
        laser_off = 1'b0;
        fault_det = 1'b0;
        opt_ok = 1'b1;
        // longer than three link cycles so the link side sees reset too
        cyc(15);
        srst <= 1'b0;
        probe(DEV_ADDR_DIAG, 1'b0);
        probe(DEV_ADDR_ID, 1'b1);
        read_status(8'h00);
        pin(laser_en, 1'b1, "laser after init");
        $display("test bus ready done");
        write_status(8'h40, 1);
        pin(laser_en, 1'b0, "soft off");
        probe(DEV_ADDR_ID, 1'b1);
        write_status(8'h00, 5);
        probe(DEV_ADDR_ID, 1'b0);
        probe(DEV_ADDR_ID, 1'b1);
        pin(laser_en, 1'b1, "soft on");
        $display("test soft control done");
        laser_off <= 1'b1;
        cyc(1000);
        pin(laser_en, 1'b0, "hard off");
        laser_off <= 1'b0;
        cyc(1000);
        pin(laser_en, 1'b1, "hard on");
        $display("test hard control done");
        fault_det <= 1'b1;
        opt_ok <= 1'b0;
        cyc(1000);
        pin(fault_pin, 1'b1, "fault pin");
        pin(los_pin, 1'b1, "los pin");
        pin(laser_en, 1'b0, "fault shutdown");
        read_status(8'h07);
        fault_det <= 1'b0;
        opt_ok <= 1'b1;
        cyc(1000);
        pin(los_pin, 1'b0, "los clear");
        laser_off <= 1'b1;
        cyc(500);
        laser_off <= 1'b0;
        cyc(1000);
        pin(fault_pin, 1'b1, "short pulse kept");
        laser_off <= 1'b1;
        cyc(1100);
        laser_off <= 1'b0;
        cyc(1000);
        pin(fault_pin, 1'b0, "fault cleared");
        pin(laser_en, 1'b1, "laser back");
        $display("test fault and loss done");
        close_out();
    end
endmodule
